// ==== design/smcs_params.svh ====
// Constants for the serial command slave: command codes, field positions,
// reset values and timing counts. Included by the top module only.
`ifndef SMCS_PARAMS_SVH
`define SMCS_PARAMS_SVH

// Command codes of the registers this block holds
`define SMCS_CMD_OPERATION 8'h01
`define SMCS_CMD_ON_OFF_CFG 8'h02
`define SMCS_CMD_CLEAR_FAULTS 8'h03
`define SMCS_CMD_MARGIN_HIGH 8'h25
`define SMCS_CMD_MARGIN_LOW 8'h26
`define SMCS_CMD_FIRST_CFG 8'hd0
`define SMCS_CMD_LOCK_RESET 8'hd1
`define SMCS_CMD_COMMANDED 8'hd2
`define SMCS_CMD_STATUS_WORD 8'hd3
`define SMCS_CMD_BLOCK_ID 8'hd4

// Field positions
`define SMCS_CFG1_TIMEOUT_BIT 3
`define SMCS_LOCK_BIT 0
`define SMCS_ONOFF_PIN_OBEY_BIT 3
`define SMCS_ONOFF_CMD_OBEY_BIT 2
`define SMCS_ONOFF_PIN_LOW_BIT 1
`define SMCS_OP_ON_BIT 7
`define SMCS_OP_SOFT_BIT 6
`define SMCS_OP_MARGIN_LSB 4

// Operation margin field encodings
`define SMCS_MARGIN_NONE 2'h0
`define SMCS_MARGIN_LOW 2'h1
`define SMCS_MARGIN_HIGH 2'h2

// Reset values
`define SMCS_RST_OPERATION 8'h00
`define SMCS_RST_ON_OFF_CFG 8'h08
`define SMCS_RST_FIRST_CFG 8'h00
`define SMCS_RST_MARGIN 8'h00
`define SMCS_RST_COMMANDED 8'h00

// Block read length in data bytes
`define SMCS_BLOCK_LEN 8'h02

// Timing
`define SMCS_CLK_HZ 20000000
`define SMCS_TIMEOUT_MS 35
`define SMCS_TIMEOUT_CYC ((`SMCS_CLK_HZ / 1000) * `SMCS_TIMEOUT_MS)

`endif

// ==== design/smcs_pkg.sv ====
// Types shared by the serial command slave.
// Assumes smcs_params.svh holds all other numbers; state codes sit here.
package smcs_pkg;

  // Byte engine states, one-hot
  typedef enum logic [5:0] {
    SMCS_IDLE = 6'h01,
    SMCS_RX = 6'h02,
    SMCS_RX_ACK = 6'h04,
    SMCS_TX = 6'h08,
    SMCS_TX_ACK = 6'h10,
    SMCS_SKIP = 6'h20
  } smcs_state_e;

  // Switching control outputs
  typedef struct packed {
    logic run;
    logic soft_stop;
    logic [7:0] target_code;
  } smcs_power_s;

endpackage

// ==== design/smcs_top.sv ====
// Serial command slave with on/off control of a regulator.
// Assumes scl_i, sda_i and en_pin_i arrive asynchronously; pad logic
// combines sda_oe with an open-drain wire outside this module.
// How it works
// - Send byte: address, ack, command, ack
// - Clear-faults send byte pulses fault clear
// - Repeated start after command begins read
// - Write byte acks address, command, data
// - Write word acks all four bytes
// - Block write carries count then N bytes
// - Block write acks every received byte
// - Read byte returns one byte after restart
// - Read word sends low byte first
// - Block read sends count then N bytes
// - Idle timeout abandons transfer, frees bus
// - First configuration bit 3 enables timeout
// - Lock bit set by write, power-cycle cleared
// - On-off config selects pin and command obey
// - Reset obeys pin, ignores command
// - Pin active high unless configured low
// - Operation offers soft and immediate off
// - Operation on runs pin-style start-up
// - Margin settings pick margin voltage codes when on-off config obeys command
// - Data needs command code in same transfer
// - Command code sets data byte count
`timescale 1ns/1ps
`include "smcs_params.svh"

module smcs_top #(
  parameter logic [6:0] DEV_ADDR = 7'h60,
  parameter int TIMEOUT_CYC = `SMCS_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Enable pin
  input wire logic en_pin_i,
  // Regulator control
  output smcs_pkg::smcs_power_s power_o,
  output logic clear_faults_o,
  output logic lock_o
);

  // Refuse a timeout that the 25-bit idle counter cannot reach
  if (TIMEOUT_CYC < 2 || TIMEOUT_CYC > 33554431) begin : g_bad_timeout
    $error("TIMEOUT_CYC out of range");
  end

  // Whole state of the block
  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic [1:0] en_sy;
    logic scl_d;
    logic sda_d;
    smcs_pkg::smcs_state_e st;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [2:0] byte_idx;
    logic rd_mode;
    logic cmd_ok;
    logic [7:0] cmd;
    logic [7:0] data0;
    logic [7:0] blk_left;
    logic [7:0] tx_byte;
    logic [24:0] idle_cnt;
    logic [7:0] operation;
    logic [7:0] on_off_cfg;
    logic [7:0] margin_high;
    logic [7:0] margin_low;
    logic [7:0] first_cfg;
    logic [7:0] commanded;
    logic lock;
    logic clr_pulse;
    logic sda_out_low;
    smcs_pkg::smcs_power_s power;
  } smcs_all_s;

  smcs_all_s s_r;
  smcs_all_s s_nxt;

  // Write data length by command code
  function automatic logic [1:0] wr_len(input logic [7:0] c);
    if (c == `SMCS_CMD_COMMANDED || c == `SMCS_CMD_STATUS_WORD) begin
      wr_len = 2'd2;
    end else if (c == `SMCS_CMD_BLOCK_ID) begin
      wr_len = 2'd3;
    end else if (c == `SMCS_CMD_CLEAR_FAULTS) begin
      wr_len = 2'd0;
    end else begin
      wr_len = 2'd1;
    end
  endfunction

  // Is a command held behind the lock
  function automatic logic locked_cmd(input logic [7:0] c);
    locked_cmd = (c == `SMCS_CMD_ON_OFF_CFG) || (c == `SMCS_CMD_MARGIN_HIGH) ||
      (c == `SMCS_CMD_MARGIN_LOW) || (c == `SMCS_CMD_FIRST_CFG);
  endfunction

  // Read data for a command and byte index
  function automatic logic [7:0] rd_byte(input smcs_all_s s, input logic [2:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (s.cmd == `SMCS_CMD_OPERATION) begin
      v = s.operation;
    end else if (s.cmd == `SMCS_CMD_ON_OFF_CFG) begin
      v = s.on_off_cfg;
    end else if (s.cmd == `SMCS_CMD_MARGIN_HIGH) begin
      v = s.margin_high;
    end else if (s.cmd == `SMCS_CMD_MARGIN_LOW) begin
      v = s.margin_low;
    end else if (s.cmd == `SMCS_CMD_FIRST_CFG) begin
      v = s.first_cfg;
    end else if (s.cmd == `SMCS_CMD_LOCK_RESET) begin
      v = {7'h00, s.lock};
    end else if (s.cmd == `SMCS_CMD_COMMANDED || s.cmd == `SMCS_CMD_STATUS_WORD) begin
      // Low byte first
      if (s.cmd == `SMCS_CMD_COMMANDED) begin
        v = (idx == 3'd0) ? s.commanded : 8'h00;
      end else begin
        v = (idx == 3'd0) ? {6'h00, s.power.soft_stop, s.power.run} : {7'h00, s.lock};
      end
    end else if (s.cmd == `SMCS_CMD_BLOCK_ID) begin
      // Count first, then data bytes
      if (idx == 3'd0) begin
        v = `SMCS_BLOCK_LEN;
      end else if (idx == 3'd1) begin
        v = s.margin_low;
      end else begin
        v = s.margin_high;
      end
    end
    rd_byte = v;
  endfunction

  // Next-state logic
  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic pin_on;
    logic cmd_on;
    logic [7:0] b;
    pin_on = 1'b0;
    cmd_on = 1'b0;
    s_nxt = s_r;
    s_nxt.scl_sy = {s_r.scl_sy[0], scl_i};
    s_nxt.sda_sy = {s_r.sda_sy[0], sda_i};
    s_nxt.en_sy = {s_r.en_sy[0], en_pin_i};
    s_nxt.scl_d = s_r.scl_sy[1];
    s_nxt.sda_d = s_r.sda_sy[1];
    s_nxt.clr_pulse = 1'b0;
    scl_rise = s_r.scl_sy[1] & ~s_r.scl_d;
    scl_fall = ~s_r.scl_sy[1] & s_r.scl_d;
    start_c = s_r.scl_sy[1] & s_r.scl_d & s_r.sda_d & ~s_r.sda_sy[1];
    stop_c = s_r.scl_sy[1] & s_r.scl_d & ~s_r.sda_d & s_r.sda_sy[1];
    b = s_r.shreg;

    // Idle counter resets on any line change
    if (s_r.scl_sy[1] != s_r.scl_d || s_r.sda_sy[1] != s_r.sda_d ||
        s_r.st == smcs_pkg::SMCS_IDLE) begin
      s_nxt.idle_cnt = 25'd0;
    end else begin
      s_nxt.idle_cnt = s_r.idle_cnt + 25'd1;
    end

    if (stop_c) begin
      // Stop ends any transfer; command must be resent
      s_nxt.st = smcs_pkg::SMCS_IDLE;
      s_nxt.cmd_ok = 1'b0;
      s_nxt.sda_out_low = 1'b0;
      if (!s_r.rd_mode && s_r.byte_idx == 3'd2 && s_r.cmd_ok &&
          s_r.cmd == `SMCS_CMD_CLEAR_FAULTS) begin
        s_nxt.clr_pulse = 1'b1;
      end
    end else if (start_c) begin
      // Start or repeated start keeps command code
      s_nxt.st = smcs_pkg::SMCS_RX;
      s_nxt.bit_cnt = 4'd0;
      s_nxt.byte_idx = 3'd0;
      s_nxt.sda_out_low = 1'b0;
    end else if (s_r.first_cfg[`SMCS_CFG1_TIMEOUT_BIT] &&
                 s_r.idle_cnt >= 25'(TIMEOUT_CYC - 1)) begin
      // Abandon and release the bus
      s_nxt.st = smcs_pkg::SMCS_IDLE;
      s_nxt.sda_out_low = 1'b0;
      s_nxt.cmd_ok = 1'b0;
    end else begin
      case (s_r.st)
        smcs_pkg::SMCS_RX: begin
          if (scl_rise) begin
            s_nxt.shreg = {s_r.shreg[6:0], s_r.sda_sy[1]};
            s_nxt.bit_cnt = s_r.bit_cnt + 4'd1;
          end else if (scl_fall && s_r.bit_cnt == 4'd8) begin
            s_nxt.bit_cnt = 4'd0;
            s_nxt.st = smcs_pkg::SMCS_RX_ACK;
            s_nxt.sda_out_low = 1'b1;
            if (s_r.byte_idx == 3'd0) begin
              if (b[7:1] != DEV_ADDR || (b[0] && !s_r.cmd_ok)) begin
                s_nxt.st = smcs_pkg::SMCS_SKIP;
                s_nxt.sda_out_low = 1'b0;
              end else begin
                s_nxt.rd_mode = b[0];
                s_nxt.tx_byte = rd_byte(s_r, 3'd0);
              end
            end else if (s_r.byte_idx == 3'd1) begin
              s_nxt.cmd = b;
              s_nxt.cmd_ok = 1'b1;
            end else if (s_r.byte_idx == 3'd2) begin
              s_nxt.data0 = b;
              s_nxt.blk_left = b; // Block count
            end
            // Store at the last byte the command carries
            if (s_r.byte_idx >= 3'd2 && 2'(s_r.byte_idx - 3'd1) == wr_len(s_r.cmd) &&
                !(s_r.lock && locked_cmd(s_r.cmd))) begin
              if (s_r.cmd == `SMCS_CMD_OPERATION) begin
                s_nxt.operation = b;
              end else if (s_r.cmd == `SMCS_CMD_ON_OFF_CFG) begin
                s_nxt.on_off_cfg = b;
              end else if (s_r.cmd == `SMCS_CMD_MARGIN_HIGH) begin
                s_nxt.margin_high = b;
              end else if (s_r.cmd == `SMCS_CMD_MARGIN_LOW) begin
                s_nxt.margin_low = b;
              end else if (s_r.cmd == `SMCS_CMD_FIRST_CFG) begin
                s_nxt.first_cfg = b;
              end else if (s_r.cmd == `SMCS_CMD_LOCK_RESET && b[`SMCS_LOCK_BIT]) begin
                s_nxt.lock = 1'b1;
              end else if (s_r.cmd == `SMCS_CMD_COMMANDED) begin
                s_nxt.commanded = s_r.data0;
              end
            end
            if (s_r.byte_idx != 3'd7) begin
              s_nxt.byte_idx = s_r.byte_idx + 3'd1;
            end
          end
        end
        smcs_pkg::SMCS_RX_ACK: begin
          // Hold ack through one clock high, release on fall
          if (scl_fall) begin
            if (s_r.rd_mode) begin
              s_nxt.st = smcs_pkg::SMCS_TX;
              s_nxt.sda_out_low = ~s_r.tx_byte[7];
              s_nxt.shreg = {s_r.tx_byte[6:0], 1'b0};
              s_nxt.bit_cnt = 4'd1;
            end else begin
              s_nxt.st = smcs_pkg::SMCS_RX;
              s_nxt.sda_out_low = 1'b0;
            end
          end
        end
        smcs_pkg::SMCS_TX: begin
          if (scl_fall) begin
            if (s_r.bit_cnt == 4'd8) begin
              s_nxt.st = smcs_pkg::SMCS_TX_ACK;
              s_nxt.sda_out_low = 1'b0;
              s_nxt.bit_cnt = 4'd0;
              s_nxt.byte_idx = s_r.byte_idx + 3'd1;
            end else begin
              s_nxt.sda_out_low = ~s_r.shreg[7];
              s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
              s_nxt.bit_cnt = s_r.bit_cnt + 4'd1;
            end
          end
        end
        smcs_pkg::SMCS_TX_ACK: begin
          // Master ack continues, nack ends the read
          if (scl_rise) begin
            if (s_r.sda_sy[1]) begin
              s_nxt.st = smcs_pkg::SMCS_SKIP;
            end else begin
              s_nxt.tx_byte = rd_byte(s_r, s_r.byte_idx - 3'd1);
            end
          end else if (scl_fall) begin
            s_nxt.st = smcs_pkg::SMCS_TX;
            s_nxt.sda_out_low = ~s_r.tx_byte[7];
            s_nxt.shreg = {s_r.tx_byte[6:0], 1'b0};
            s_nxt.bit_cnt = 4'd1;
          end
        end
        default: begin
          // Idle or skipping: wait for start or stop
          s_nxt.sda_out_low = 1'b0;
        end
      endcase
    end

    // Power control from pin and operation command
    pin_on = (s_r.en_sy[1] ^ s_r.on_off_cfg[`SMCS_ONOFF_PIN_LOW_BIT]) |
      ~s_r.on_off_cfg[`SMCS_ONOFF_PIN_OBEY_BIT];
    cmd_on = s_r.operation[`SMCS_OP_ON_BIT] |
      ~s_r.on_off_cfg[`SMCS_ONOFF_CMD_OBEY_BIT];
    s_nxt.power.run = pin_on & cmd_on;
    s_nxt.power.soft_stop = ~cmd_on & s_r.operation[`SMCS_OP_SOFT_BIT];
    s_nxt.power.target_code = s_r.commanded;
    if (s_r.on_off_cfg[`SMCS_ONOFF_CMD_OBEY_BIT]) begin
      if (s_r.operation[`SMCS_OP_MARGIN_LSB +: 2] == `SMCS_MARGIN_HIGH) begin
        s_nxt.power.target_code = s_r.margin_high;
      end else if (s_r.operation[`SMCS_OP_MARGIN_LSB +: 2] == `SMCS_MARGIN_LOW) begin
        s_nxt.power.target_code = s_r.margin_low;
      end
    end
  end

  // State register
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.scl_sy <= 2'b11;
      s_r.sda_sy <= 2'b11;
      s_r.scl_d <= 1'b1;
      s_r.sda_d <= 1'b1;
      s_r.st <= smcs_pkg::SMCS_IDLE;
      s_r.operation <= `SMCS_RST_OPERATION;
      s_r.on_off_cfg <= `SMCS_RST_ON_OFF_CFG;
      s_r.first_cfg <= `SMCS_RST_FIRST_CFG;
      s_r.margin_high <= `SMCS_RST_MARGIN;
      s_r.margin_low <= `SMCS_RST_MARGIN;
      s_r.commanded <= `SMCS_RST_COMMANDED;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from state; sda_o tied low
  assign sda_o = 1'b0;
  assign sda_oe = s_r.sda_out_low;
  assign power_o = s_r.power;
  assign clear_faults_o = s_r.clr_pulse;
  assign lock_o = s_r.lock;

endmodule // smcs_top

// ==== verification/smcs_asserts.sv ====
// Port checker for the serial command slave.
// Assumes it is bound to smcs_top and sees its ports only.
`timescale 1ns/1ps
module smcs_asserts #(
  parameter logic [6:0] DEV_ADDR = 7'h60,
  parameter int TIMEOUT_CYC = 200
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Control pins
  input wire logic en_pin_i,
  input wire smcs_pkg::smcs_power_s power_o,
  input wire logic clear_faults_o,
  input wire logic lock_o
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Start: data falls with clock high
  sequence s_start; scl_i && $fell(sda_i); endsequence
  // Bus idle: both lines high
  sequence s_idle; scl_i && sda_i; endsequence
  property p_open_drain; sda_o == 1'b0; endproperty
  property p_clr_pulse; clear_faults_o |=> !clear_faults_o; endproperty
  property p_clr_idle; clear_faults_o |-> s_idle; endproperty
  property p_lock_hold; lock_o |=> lock_o; endproperty
  property p_lock_rst; $fell(sys_rst) |-> !lock_o; endproperty
  property p_start_quiet; s_start |-> !sda_oe [*4]; endproperty
  property p_ack_hold; $rose(sda_oe) |-> sda_oe [*6]; endproperty
  property p_oe_scl_low; $changed(sda_oe) |-> !scl_i; endproperty
  property p_soft_off; power_o.soft_stop |-> !power_o.run; endproperty
  a_open_drain: assert property (p_open_drain) else $error("data driven high");
  a_clr_pulse: assert property (p_clr_pulse) else $error("clear pulse too long");
  a_clr_idle: assert property (p_clr_idle) else $error("clear before stop");
  a_lock_hold: assert property (p_lock_hold) else $error("lock dropped");
  a_lock_rst: assert property (p_lock_rst) else $error("lock kept over reset");
  a_start_quiet: assert property (p_start_quiet) else $error("drive after start");
  a_ack_hold: assert property (p_ack_hold) else $error("ack too short");
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved, clock high");
  a_soft_off: assert property (p_soft_off) else $error("soft off while running");
endmodule // smcs_asserts

// ==== verification/smcs_master.sv ====
// Bus master model for the serial command slave.
// Assumes tb_top resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
module smcs_master #(
  parameter logic [6:0] ADDR = 7'h60
) (
  // Clock
  input wire logic mclk,
  // Bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  localparam int H = 5; // Half bit in clocks
  logic [7:0] rx [4]; // Bytes read
  int acks; // Acks in last transfer
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Wait n clocks, step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Set both lines, hold half a bit
  task automatic ph(input logic c, input logic d);
    scl = c;
    sda_low = !d;
    cyc(H);
  endtask
  // Start or repeated start
  task automatic start();
    cyc(2);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    scl = 1'b0;
  endtask
  // Stop, data rises with clock high
  task automatic stop();
    cyc(2);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  // One bit, sampled at end of high phase
  task automatic bit_x(input logic b, output logic r);
    cyc(2);
    ph(1'b0, b);
    scl = 1'b1;
    cyc(H);
    r = sda;
    scl = 1'b0;
  endtask
  // Byte out, count its acknowledge
  task automatic put(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    acks += int'(r === 1'b0);
  endtask
  // Byte in, then ack or no ack
  task automatic get(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(!ack, r);
  endtask
  // Write: address, command, n bytes, stop
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [31:0] w, input int n);
    acks = 0;
    start();
    put({a, 1'b0});
    put(c);
    for (int k = 0; k < n; k++) put(w[8*k+:8]);
    stop();
  endtask
  // Command, repeated start, n bytes read
  task automatic rd(input logic [7:0] c, input int n);
    acks = 0;
    start();
    put({ADDR, 1'b0});
    put(c);
    start();
    put({ADDR, 1'b1});
    for (int k = 0; k < n; k++) get(k < n - 1, rx[k]);
    stop();
  endtask
  // Command bits, then clock held low
  task automatic stall(input logic [7:0] c, input int t);
    logic r;
    start();
    put({ADDR, 1'b0});
    for (int i = 7; i >= 0; i--) bit_x(c[i], r);
    cyc(t);
  endtask
endmodule // smcs_master

// ==== verification/tb_top.sv ====
// Self-checking bench for the serial command slave.
// Assumes smcs_master as bus partner and smcs_asserts bound in.
`timescale 1ns/1ps
bind smcs_top smcs_asserts #(.DEV_ADDR(DEV_ADDR), .TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .en_pin_i(en_pin_i), .power_o(power_o),
  .clear_faults_o(clear_faults_o), .lock_o(lock_o));
module tb_top;
  localparam int TO = 200; // Short idle limit
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic en_pin = 1'b1;
  logic sda_o, sda_oe, clr, lock_o, scl, sda_low;
  wire sda = !(sda_low || sda_oe); // Pulled-up data wire
  smcs_pkg::smcs_power_s pwr;
  int error_cnt = 0;
  int n_compared = 0;
  int clr_n = 0; // Clear pulses seen
  // 50 ns period
  always #25 mclk = ~mclk;
  // Count clear pulses
  always @(posedge mclk) if (clr === 1'b1) clr_n++;
  smcs_top #(.TIMEOUT_CYC(TO)) dut (.mclk(mclk), .sys_rst(sys_rst),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .en_pin_i(en_pin),
    .power_o(pwr), .clear_faults_o(clr), .lock_o(lock_o));
  smcs_master m (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
  // Compare one value
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  // Write to own address
  task automatic w(input logic [7:0] c, input logic [31:0] v, input int n);
    m.wr(7'h60, c, v, n);
  endtask
  task automatic t_reset();
    m.rd(8'h02, 1);
    chk("onoff", 8'h08, m.rx[0]);
    m.rd(8'h01, 1);
    chk("op", 8'h00, m.rx[0]);
    chk("run hi", 8'h01, 8'(pwr.run));
    en_pin = 1'b0;
    m.cyc(10);
    chk("run lo", 8'h00, 8'(pwr.run));
    $display("t_reset done");
  endtask
  task automatic t_regs();
    w(8'h25, 32'h5a, 1);
    chk("acks", 8'h03, 8'(m.acks));
    w(8'h26, 32'h33, 1);
    m.wr(7'h61, 8'h25, 32'h00, 1);
    chk("acks", 8'h00, 8'(m.acks));
    m.rd(8'h25, 1);
    chk("mhi", 8'h5a, m.rx[0]);
    w(8'hd2, 32'h77, 2);
    chk("acks", 8'h04, 8'(m.acks));
    m.rd(8'hd2, 2);
    chk("word lo", 8'h77, m.rx[0]);
    chk("word hi", 8'h00, m.rx[1]);
    m.rd(8'hd4, 3);
    chk("count", 8'h02, m.rx[0]);
    chk("blk0", 8'h33, m.rx[1]);
    chk("blk1", 8'h5a, m.rx[2]);
    $display("t_regs done");
  endtask
  task automatic t_onoff();
    logic [7:0] op [6] = '{8'h80, 8'ha0, 8'h90, 8'h40, 8'h80, 8'h00};
    logic [9:0] ex [6] = '{10'h277, 10'h25a, 10'h233, 10'h100, 10'h277, 10'h000};
    w(8'h02, 32'h04, 1);
    for (int i = 0; i < 6; i++) begin
      w(8'h01, 32'(op[i]), 1);
      chk("state", 8'(ex[i][9:8]), 8'(pwr[9:8]));
      if (ex[i][9]) chk("target", ex[i][7:0], pwr.target_code);
    end
    en_pin = 1'b1;
    m.cyc(10);
    chk("pin ign", 8'h00, 8'(pwr.run));
    w(8'h02, 32'h0a, 1);
    en_pin = 1'b0;
    m.cyc(10);
    chk("pin lo", 8'h01, 8'(pwr.run));
    $display("t_onoff done");
  endtask
  task automatic t_misc();
    logic r;
    for (int k = 0; k < 2; k++) begin
      w(8'hd0, 32'(k * 8), 1);
      m.stall(8'h01, TO + 20);
      chk("held", 8'(k == 0), 8'(sda_oe));
      chk("sda_o", 8'h00, 8'(sda_o));
      m.bit_x(1'b1, r);
      m.stop();
    end
    clr_n = 0;
    w(8'h03, 32'h0, 0);
    chk("acks", 8'h02, 8'(m.acks));
    m.cyc(8);
    chk("clears", 8'h01, 8'(clr_n));
    w(8'hd4, 32'h11223303, 4);
    chk("acks", 8'h06, 8'(m.acks));
    $display("t_misc done");
  endtask
  task automatic t_lock();
    w(8'hd1, 32'h01, 1);
    chk("lock", 8'h01, 8'(lock_o));
    w(8'hd0, 32'h00, 1);
    m.rd(8'hd0, 1);
    chk("cfg1", 8'h08, m.rx[0]);
    m.rd(8'hd3, 2);
    chk("status lo", 8'h01, m.rx[0]);
    chk("status hi", 8'h01, m.rx[1]);
    sys_rst = 1'b1;
    m.cyc(2);
    sys_rst = 1'b0;
    m.cyc(4);
    chk("unlock", 8'h00, 8'(lock_o));
    $display("t_lock done");
  endtask
  // Print counts and verdict, end the run
  task automatic stop_test();
    $display("Compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog: the tests need about 12000 clocks
  initial begin
    repeat (40000) @(posedge mclk);
    error_cnt++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    m.cyc(4);
    t_reset();
    t_regs();
    t_onoff();
    t_misc();
    t_lock();
    stop_test();
  end
endmodule // tb_top
